// [verilog/srg_cmd.sv]
`timescale 1ns/1ps
module srg_cmd (
	input  wire logic                      clk,
	input  wire logic                      srst,
	input  wire logic                      cs_n,
	input  wire logic                      sclk,
	input  wire logic                      din,
	output logic                           dout,
	input  wire logic [3:0]                pin_in,
	output logic      [3:0]                pin_out,
	output logic      [3:0]                pin_oe,
	output logic                           bias_force_on,
	output logic                           slow_out,
	output logic                           fifo_clear,
	output logic                           full_reset,
	output logic      [7:0]                setup_state,
	output logic                           wakeup_skip,
	output srg_pkg::srg_dac_word_type      dac_word,
	output logic                           dac_word_valid,
	output logic                           dac_reg_clear,
	output logic                           dac_reg_preset
);
	logic                  sclk_s1, sclk_s2, sclk_d;
	logic                  cs_s1, cs_s2, cs_d;
	logic                  din_s1, din_s2;
	logic [3:0]            pin_s1, pin_s2;
	logic                  sclk_fall;
	logic                  cs_rise;
	logic                  unit_done;
	logic                  cmd_done;
	logic [4:0]            bit_cnt;
	logic [15:0]           shift;
	logic [15:0]           next_shift;
	logic [7:0]            next_byte;
	srg_pkg::srg_state_type state;
	logic [7:0]            pin_cfg, pin_wr;
	logic [7:0]            cfg_pend, wr_pend;
	logic                  cfg_have, wr_have;
	logic [7:0]            rd_shift;
	logic                  dout_q;
	logic [srg_pkg::SLOW_CYCLES-1:0] dly;

	function automatic logic is_cmd(input logic [7:0] b, input logic [7:0] m,
			input logic [7:0] v);
		is_cmd = (b & m) == v;
	endfunction

	// first stages feed only the second stages
	always_ff @(posedge clk) begin
		sclk_s1 <= sclk;
		sclk_s2 <= sclk_s1;
		sclk_d  <= sclk_s2;
		cs_s1   <= cs_n;
		cs_s2   <= cs_s1;
		cs_d    <= cs_s2;
		din_s1  <= din;
		din_s2  <= din_s1;
		pin_s1  <= pin_in;
		pin_s2  <= pin_s1;
	end

	assign sclk_fall  = sclk_d && !sclk_s2 && !cs_s2;
	assign cs_rise    = !cs_d && cs_s2;
	assign next_shift = {shift[14:0], din_s2};
	assign next_byte  = next_shift[7:0];
	assign unit_done  = sclk_fall
		&& (bit_cnt == ((state == srg_pkg::ST_DAC) ? srg_pkg::DAC_LAST : srg_pkg::BYTE_LAST));
	assign cmd_done   = unit_done && (state == srg_pkg::ST_CMD);

	// frame bit counter; chip select high holds it idle
	always_ff @(posedge clk) begin
		if (srst || cs_s2) begin
			bit_cnt <= 5'h00;
			shift   <= 16'h0000;
		end else if (sclk_fall) begin
			shift   <= next_shift;
			bit_cnt <= unit_done ? 5'h00 : bit_cnt + 5'h01;
		end
	end

	// a dropped frame falls back to command state, losing any partial DAC word
	always_ff @(posedge clk) begin
		if (srst || cs_s2) begin
			state <= srg_pkg::ST_CMD;
		end else if (unit_done) begin
			case (state)
				srg_pkg::ST_CMD: begin
					if (is_cmd(next_byte, srg_pkg::CMD_DAC_MASK, srg_pkg::CMD_DAC_VAL)) begin
						state <= srg_pkg::ST_DAC;
					end else if (is_cmd(next_byte, srg_pkg::CMD_PIN_MASK,
							srg_pkg::CMD_PIN_VAL)) begin
						case (next_byte[1:0])
							srg_pkg::PIN_OP_CONFIG: state <= srg_pkg::ST_CFG;
							srg_pkg::PIN_OP_WRITE:  state <= srg_pkg::ST_WR;
							srg_pkg::PIN_OP_READ:   state <= srg_pkg::ST_RD;
							default:                state <= srg_pkg::ST_CMD;
						endcase
					end else begin
						state <= srg_pkg::ST_CMD;
					end
				end
				default: state <= srg_pkg::ST_CMD;
			endcase
		end
	end

	// reset command decode
	always_ff @(posedge clk) begin
		if (srst) begin
			bias_force_on <= 1'b0;
			slow_out      <= 1'b0;
			fifo_clear    <= 1'b0;
			full_reset    <= 1'b0;
		end else begin
			fifo_clear <= 1'b0;
			full_reset <= 1'b0;
			if (cmd_done && is_cmd(next_byte, srg_pkg::CMD_RESET_MASK,
					srg_pkg::CMD_RESET_VAL)) begin
				full_reset    <= next_byte[srg_pkg::RST_FULL_BIT];
				slow_out      <= next_byte[srg_pkg::RST_SLOW_BIT];
				bias_force_on <= next_byte[srg_pkg::RST_BIAS_BIT];
				fifo_clear    <= !next_byte[srg_pkg::RST_FULL_BIT]
					|| next_byte[srg_pkg::RST_SLOW_BIT]
					|| next_byte[srg_pkg::RST_BIAS_BIT];
			end
		end
	end

	// setup register lives elsewhere; only its power-on image is held here
	always_ff @(posedge clk) begin
		if (srst || full_reset) begin
			setup_state <= srg_pkg::SETUP_RESET;
		end
	end

	assign wakeup_skip = bias_force_on && setup_state[srg_pkg::CKSEL_LOW_BIT];

	// pin data bytes wait for chip-select rise so a half shifted byte never shows
	always_ff @(posedge clk) begin
		if (srst || cs_rise) begin
			cfg_have <= 1'b0;
			wr_have  <= 1'b0;
		end else if (unit_done && state == srg_pkg::ST_CFG) begin
			cfg_pend <= next_byte;
			cfg_have <= 1'b1;
		end else if (unit_done && state == srg_pkg::ST_WR) begin
			wr_pend <= next_byte;
			wr_have <= 1'b1;
		end
	end

	// not touched by full_reset
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_cfg <= srg_pkg::PIN_CFG_RESET;
			pin_wr  <= srg_pkg::PIN_WR_RESET;
		end else if (cs_rise) begin
			if (cfg_have) begin
				pin_cfg <= cfg_pend;
			end
			if (wr_have) begin
				pin_wr <= wr_pend;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			always_ff @(posedge clk) begin
				if (srst) begin
					pin_out[gi] <= 1'b0;
					pin_oe[gi]  <= 1'b0;
				end else begin
					// driven high only when configured as output, else low or released
					pin_out[gi] <= pin_cfg[srg_pkg::PIN_FIELD_LSB+gi]
						&& pin_wr[srg_pkg::PIN_FIELD_LSB+gi];
					pin_oe[gi]  <= pin_cfg[srg_pkg::PIN_FIELD_LSB+gi]
						|| !pin_wr[srg_pkg::PIN_FIELD_LSB+gi];
				end
			end
			// each pin mode against the register bits one cycle earlier
			AST_PIN_DRIVEN: assert property (@(posedge clk) disable iff (srst)
				pin_cfg[srg_pkg::PIN_FIELD_LSB+gi]
				|=> pin_oe[gi] && pin_out[gi] == $past(pin_wr[srg_pkg::PIN_FIELD_LSB+gi]))
				else $error("output pin not driving its write bit");
			AST_PIN_FLOAT: assert property (@(posedge clk) disable iff (srst)
				!pin_cfg[srg_pkg::PIN_FIELD_LSB+gi] && pin_wr[srg_pkg::PIN_FIELD_LSB+gi]
				|=> !pin_oe[gi])
				else $error("input pin not released");
			AST_PIN_PULL: assert property (@(posedge clk) disable iff (srst)
				!pin_cfg[srg_pkg::PIN_FIELD_LSB+gi] && !pin_wr[srg_pkg::PIN_FIELD_LSB+gi]
				|=> pin_oe[gi] && !pin_out[gi])
				else $error("pulldown pin not driving low");
		end
	endgenerate

	// read data: four zero bits, then C1 C0 A1 A0
	always_ff @(posedge clk) begin
		if (srst || cs_s2) begin
			rd_shift <= 8'h00;
		end else if (cmd_done && next_byte == {6'h00, srg_pkg::PIN_OP_READ}) begin
			rd_shift <= {srg_pkg::PIN_READ_PAD, pin_s2};
		end else if (sclk_fall && state == srg_pkg::ST_RD) begin
			rd_shift <= {rd_shift[6:0], 1'b0};
		end
	end

	// output delay line; slow mode trades speed for hold margin
	always_ff @(posedge clk) begin
		if (srst) begin
			dout_q <= 1'b0;
			dly    <= '0;
			dout   <= 1'b0;
		end else begin
			dout_q <= (state == srg_pkg::ST_RD) && rd_shift[7];
			dly    <= {dly[srg_pkg::SLOW_CYCLES-2:0], dout_q};
			dout   <= slow_out ? dly[srg_pkg::SLOW_CYCLES-1] : dout_q;
		end
	end

	// DAC word capture on the sixteenth falling edge only
	always_ff @(posedge clk) begin
		if (srst) begin
			dac_word       <= '0;
			dac_word_valid <= 1'b0;
			dac_reg_clear  <= 1'b0;
			dac_reg_preset <= 1'b0;
		end else begin
			dac_word_valid <= 1'b0;
			dac_reg_clear  <= 1'b0;
			dac_reg_preset <= 1'b0;
			if (unit_done && state == srg_pkg::ST_DAC) begin
				dac_word       <= next_shift;
				dac_word_valid <= 1'b1;
				if (next_shift[15:12] == srg_pkg::DAC_CTRL_RESET) begin
					dac_reg_clear  <= !next_shift[11];
					dac_reg_preset <= next_shift[11];
				end
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// full bit with slow or bias set also pulses the fifo clear, so bare code only
	AST_FULL_RESET: assert property (cmd_done && next_byte[7:2] == 6'h03
		&& next_byte[1:0] == 2'h0
		|=> full_reset && !fifo_clear ##1 setup_state == srg_pkg::SETUP_RESET)
		else $error("full reset command not honoured");
	AST_FIFO_ONLY: assert property (cmd_done && next_byte[7:2] == 6'h02
		|=> fifo_clear && !full_reset)
		else $error("fifo clear command not honoured");
	AST_SLOW_CLEARS: assert property (cmd_done && next_byte[7:3] == 5'h01
		&& next_byte[srg_pkg::RST_SLOW_BIT]
		|=> fifo_clear && slow_out)
		else $error("slow bit write did not clear fifo");
	AST_BIAS_CLEARS: assert property (cmd_done && next_byte[7:3] == 5'h01
		&& next_byte[srg_pkg::RST_BIAS_BIT]
		|=> fifo_clear && bias_force_on)
		else $error("bias force write did not clear fifo");
	AST_PINS_KEEP: assert property (full_reset |-> ##1 $stable(pin_cfg)
		&& $stable(pin_wr))
		else $error("full reset disturbed pin registers");
	AST_PIN_UPDATE: assert property ($changed(pin_cfg) || $changed(pin_wr)
		|-> $past(cs_rise))
		else $error("pin register changed outside chip-select rise");
	AST_POWER_INPUT: assert property ($fell(srst) |=> pin_oe == 4'h0)
		else $error("pins not inputs after reset");
	AST_DAC_DISCARD: assert property (cs_rise && state == srg_pkg::ST_DAC
		|=> !dac_word_valid [*3])
		else $error("partial DAC word was accepted");
	// watched at the pin three cycles on, one short of the four-cycle slow path from state
	AST_QUIET_DOUT: assert property (state == srg_pkg::ST_CFG
		|| state == srg_pkg::ST_WR |-> ##3 !dout)
		else $error("data out not zero during pin write");
	AST_SLOW_PATH: assert property (slow_out && $past(slow_out)
		|-> dout == $past(dout_q, srg_pkg::SLOW_CYCLES + 1))
		else $error("slow mode delay wrong");
	// skip only in clock modes 01 and 11, and only with bias forced on
	AST_WAKE_SKIP: assert property (wakeup_skip == (bias_force_on
		&& (setup_state[srg_pkg::CKSEL_LOW_BIT+:2] == 2'h1
		|| setup_state[srg_pkg::CKSEL_LOW_BIT+:2] == 2'h3)))
		else $error("wake-up skip does not follow bias force and clock mode");
	AST_PIN_DECODE: assert property (cmd_done && next_byte == 8'h03
		|=> state == srg_pkg::ST_CFG)
		else $error("configure command not decoded");
	AST_PIN_WRITE_DECODE: assert property (cmd_done && next_byte == 8'h02
		|=> state == srg_pkg::ST_WR)
		else $error("write command not decoded");
	AST_PIN_READ_DECODE: assert property (cmd_done && next_byte == 8'h01
		|=> state == srg_pkg::ST_RD)
		else $error("read command not decoded");
	// the empty pin code must not swallow the next byte
	AST_PIN_NONE: assert property (cmd_done && next_byte == 8'h00
		|=> state == srg_pkg::ST_CMD)
		else $error("empty pin command was not ignored");
	AST_CMD_AGAIN: assert property (unit_done && state != srg_pkg::ST_CMD
		|=> state == srg_pkg::ST_CMD)
		else $error("data unit not followed by a command byte");
	AST_DAC_FRAME: assert property (cmd_done && next_byte[7:4] == 4'h1
		|=> state == srg_pkg::ST_DAC)
		else $error("DAC select not decoded");
	AST_DAC_CODE: assert property (dac_word_valid
		&& dac_word.ctrl == srg_pkg::DAC_CTRL_RESET
		|-> dac_reg_clear == !dac_word.data[11] && dac_reg_preset == dac_word.data[11])
		else $error("DAC clear or preset wrong");
	AST_DAC_QUIET: assert property (!dac_word_valid
		|-> !dac_reg_clear && !dac_reg_preset)
		else $error("DAC clear or preset without a word");
	AST_SLOW_HOLD: assert property ($changed(slow_out) || $changed(bias_force_on)
		|-> $past(cmd_done))
		else $error("slow or bias bit changed outside a reset command");

	COV_RESET_CMD: cover property (cmd_done ##1 full_reset);
	COV_DAC_WORD: cover property (dac_word_valid);
	COV_PIN_READ: cover property (state == srg_pkg::ST_RD ##1 state == srg_pkg::ST_CMD);
	COV_PIN_CFG: cover property (cs_rise && cfg_have);
	COV_DAC_CUT: cover property (cs_rise && state == srg_pkg::ST_DAC);
endmodule

// [verilog/srg_pkg.sv]
package srg_pkg;
	localparam int CLK_MHZ       = 125;
	localparam int SLOW_DELAY_NS = 15;
	// least delay, so round up to whole cycles
	localparam int SLOW_CYCLES   = (SLOW_DELAY_NS * CLK_MHZ + 999) / 1000;

	localparam logic [4:0] BYTE_LAST = 5'h07;
	localparam logic [4:0] DAC_LAST  = 5'h0f;

	localparam logic [7:0] CMD_RESET_MASK = 8'hf8;
	localparam logic [7:0] CMD_RESET_VAL  = 8'h08;
	localparam logic [7:0] CMD_PIN_MASK   = 8'hfc;
	localparam logic [7:0] CMD_PIN_VAL    = 8'h00;
	localparam logic [7:0] CMD_DAC_MASK   = 8'hf0;
	localparam logic [7:0] CMD_DAC_VAL    = 8'h10;

	localparam logic [1:0] PIN_OP_CONFIG = 2'h3;
	localparam logic [1:0] PIN_OP_WRITE  = 2'h2;
	localparam logic [1:0] PIN_OP_READ   = 2'h1;

	localparam int RST_FULL_BIT = 2;
	localparam int RST_SLOW_BIT = 1;
	localparam int RST_BIAS_BIT = 0;

	// clock mode 10: clock_select_high and reference_select_high set
	localparam logic [7:0] SETUP_RESET   = 8'h28;
	localparam int         CKSEL_LOW_BIT = 4;

	localparam logic [3:0] DAC_CTRL_RESET = 4'h1;
	localparam int         PIN_FIELD_LSB  = 4;
	localparam logic [7:0] PIN_CFG_RESET  = 8'h00;
	// write bits high so every pin powers up as a tri-stated input
	localparam logic [7:0] PIN_WR_RESET   = 8'hf0;
	localparam logic [3:0] PIN_READ_PAD   = 4'h0;

	typedef struct packed {
		logic [3:0]  ctrl;
		logic [11:0] data;
	} srg_dac_word_type;

	typedef enum logic [2:0] {
		ST_CMD,
		ST_CFG,
		ST_WR,
		ST_RD,
		ST_DAC
	} srg_state_type;
endpackage

// [verilog/srg_dummy_none.sv]
`timescale 1ns/1ps

// [verif/srg_host_model.sv]
`timescale 1ns/1ps
module srg_host_model (
	input  wire logic clk,
	input  wire logic dout,
	output logic      cs_n,
	output logic      sclk,
	output logic      din
);
	// sclk idles high and stands still between frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din  = 1'b0;
	end

	task automatic open_frame();
		@(negedge clk);
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
	endtask

	// byte sent msb first; dout sampled just before each fall, 10 clk per bit
	task automatic send_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			din = tx[i];
			@(negedge clk);
			rx[i] = dout;
			sclk = 1'b0;
			repeat (5) @(negedge clk);
			sclk = 1'b1;
			repeat (4) @(negedge clk);
		end
	endtask

	// released data line shows the inverse so a stale value cannot pass
	task automatic close_frame();
		cs_n = 1'b1;
		din  = ~din;
		repeat (8) @(negedge clk);
	endtask
endmodule

// [verif/srg_cmd_tb_top.sv]
`timescale 1ns/1ps
module srg_cmd_tb_top;
	logic                      clk;
	logic                      srst;
	logic                      cs_n;
	logic                      sclk;
	logic                      din;
	logic                      dout;
	logic [3:0]                pin_ext;
	logic [3:0]                pin_out;
	logic [3:0]                pin_oe;
	logic [3:0]                pin_lvl;
	logic                      bias_force_on;
	logic                      slow_out;
	logic                      fifo_clear;
	logic                      full_reset;
	logic [7:0]                setup_state;
	logic                      wakeup_skip;
	srg_pkg::srg_dac_word_type dac_word;
	logic                      dac_word_valid;
	logic                      dac_reg_clear;
	logic                      dac_reg_preset;
	int                        error_cnt;
	int                        checked;
	int                        n_fifo;
	int                        n_full;
	int                        n_valid;
	int                        n_clr;
	int                        n_pre;

	// pin wire: device drive where enabled, else the outside level
	assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & pin_ext);

	srg_cmd i_dut (.clk(clk), .srst(srst), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
		.pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .bias_force_on(bias_force_on),
		.slow_out(slow_out), .fifo_clear(fifo_clear), .full_reset(full_reset),
		.setup_state(setup_state), .wakeup_skip(wakeup_skip), .dac_word(dac_word),
		.dac_word_valid(dac_word_valid), .dac_reg_clear(dac_reg_clear),
		.dac_reg_preset(dac_reg_preset));

	srg_host_model i_host (.clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(negedge clk) begin
		n_fifo  += int'(fifo_clear === 1'b1);
		n_full  += int'(full_reset === 1'b1);
		n_valid += int'(dac_word_valid === 1'b1);
		n_clr   += int'(dac_reg_clear === 1'b1);
		n_pre   += int'(dac_reg_preset === 1'b1);
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic xfer(input int n, input logic [7:0] b0, input logic [15:0] w,
			output logic [15:0] rx);
		logic [7:0] r0;
		logic [7:0] r1;
		logic [7:0] r2;
		i_host.open_frame();
		i_host.send_byte(b0, r0);
		if (n > 1) i_host.send_byte(w[15:8], r1);
		if (n > 2) i_host.send_byte(w[7:0], r2);
		rx = {r0, r1};
		i_host.close_frame();
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		$display("Error watchdog expected finish seen timeout");
		complete_run();
	end

	initial begin
		logic [7:0]  r [4];
		logic [15:0] rx;
		logic [7:0]  rc [4] = '{8'h08, 8'h09, 8'h0c, 8'h0a};
		logic [3:0]  ef [4] = '{4'h8, 4'h9, 4'h4, 4'ha};
		logic [15:0] tw [4] = '{16'h1abc, 16'h1234, 16'h2567, 16'h2567};
		logic [15:0] dw [4] = '{16'h1abc, 16'h1234, 16'h1234, 16'h2567};
		logic [2:0]  ep [4] = '{3'b101, 3'b110, 3'b000, 3'b100};
		int          dn [4] = '{3, 3, 2, 3};
		int          f0, u0, v0, c0, p0;
		srst = 1'b1;
		pin_ext = 4'h5;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		repeat (3) @(negedge clk);
		chk("pin_oe", 16'h0, 16'(pin_oe));
		chk("setup_state", 16'h28, 16'(setup_state));
		$display("test power_on done");
		// config then write in one frame, applied only at chip-select rise
		i_host.open_frame();
		i_host.send_byte(8'h03, r[0]);
		i_host.send_byte(8'ha0, r[1]);
		i_host.send_byte(8'h02, r[2]);
		i_host.send_byte(8'h60, r[3]);
		chk("pin_oe", 16'h0, 16'(pin_oe));
		chk("dout", 16'h0, {r[0] | r[1], r[2] | r[3]});
		i_host.close_frame();
		chk("pin_oe", 16'hb, 16'(pin_oe));
		chk("pin_out", 16'h2, 16'(pin_out));
		xfer(2, 8'h01, 16'h0, rx);
		chk("read", 16'h0006, rx);
		$display("test pins done");
		for (int i = 0; i < 4; i++) begin
			f0 = n_fifo;
			u0 = n_full;
			xfer(1, rc[i], 16'h0, rx);
			chk("fifo_clear", 16'(ef[i][3]), 16'(n_fifo - f0));
			chk("full_reset", 16'(ef[i][2]), 16'(n_full - u0));
			chk("slow_out", 16'(ef[i][1]), 16'(slow_out));
			chk("bias_force_on", 16'(ef[i][0]), 16'(bias_force_on));
			chk("wakeup_skip", 16'(ef[i][0] & srg_pkg::SETUP_RESET[srg_pkg::CKSEL_LOW_BIT]),
				16'(wakeup_skip));
		end
		chk("setup_state", 16'h28, 16'(setup_state));
		chk("pin_oe", 16'hb, 16'(pin_oe));
		chk("pin_out", 16'h2, 16'(pin_out));
		// slow output path still lands inside the host bit window
		pin_ext = 4'ha;
		xfer(2, 8'h01, 16'h0, rx);
		chk("read slow", 16'h0002, rx);
		$display("test reset_cmd done");
		for (int i = 0; i < 4; i++) begin
			v0 = n_valid;
			c0 = n_clr;
			p0 = n_pre;
			xfer(dn[i], 8'h10 + 8'(i), tw[i], rx);
			chk("dac_word", dw[i], dac_word);
			chk("dac_word_valid", 16'(ep[i][2]), 16'(n_valid - v0));
			chk("dac_reg_clear", 16'(ep[i][1]), 16'(n_clr - c0));
			chk("dac_reg_preset", 16'(ep[i][0]), 16'(n_pre - p0));
		end
		$display("test dac done");
		// empty pin code is dropped, so the next byte is a fresh write command
		xfer(3, 8'h00, 16'h02f0, rx);
		chk("dout", 16'h0, rx);
		chk("pin_oe", 16'ha, 16'(pin_oe));
		chk("pin_out", 16'ha, 16'(pin_out));
		$display("test pin_ignore done");
		complete_run();
	end
endmodule
